/* logic/lsu_pkg.sv */
// types and constants of the load/store and move unit
package lsu_pkg;
   typedef enum logic [2:0] {OP_NONE, OP_LOAD, OP_STORE, OP_MOVW, OP_IMMEDIATE_COPY_OP, OP_DOUBLE_COPY_OP} op_t;
   typedef enum logic [2:0] {AM_REG, AM_POSTINC, AM_DISP, AM_IO, AM_NEXT, AM_STACK} mode_t;
   typedef enum logic [2:0] {DT_BS, DT_BU, DT_HS, DT_HU, DT_W, DT_D} dtype_t;
   typedef struct packed {
      logic [31:0] data;
      logic [1:0] lane;
      dtype_t kind;
   } sentry_t;
   typedef struct packed {
      logic [5:0] dest;
      logic [1:0] lane;
      dtype_t kind;
   } lentry_t;
   localparam logic [1:0] STORE_DEPTH = 2'd2;
   localparam logic [1:0] LOAD_DEPTH = 2'd2;
   localparam logic [31:0] WORD_STEP = 32'h4;
   localparam logic [31:0] DWORD_STEP = 32'h8;
   localparam logic [31:0] REG_CTRL = 32'h0;
   localparam logic [31:0] REG_STATUS = 32'h4;
   localparam logic [31:0] REG_TRAPS = 32'h8;
   localparam int CTRL_HOLD_BIT = 0;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : lsu_pkg

/* logic/load_store_move_unit.sv */
// load/store and register-move execution unit with store and load pipelines
// How it works
// - second access at address plus four happens only for double-word
// - postincrement uses base address, then base grows by 4 or 8
// - next/stack use old base, then base plus displacement; second at old+4
// - io modes target io space and take only word and double-word
// - register/postinc: W,D; stack: W; displacement, absolute, next: all six
// - word and double-word store data is passed unchanged
// - byte or halfword placed on lane chosen by low address bits
// - partial stores enable only the addressed byte lanes
// - signed byte/halfword out of range traps, data still written
// - status word as store source stores zero, both words for double
// - each store pushes data, lane and type, then starts a cycle
// - double store pushes pair data and starts a cycle at plus four
// - issue continues without waiting for store cycles to finish; a single store waits while the store pipeline is full, a double store until it is empty
// - head store entry is driven on demand, then removed
// - pair equal to base in next/postinc double stores writes new base
// - word move/immediate set zero and sign; immediate clears overflow
// - double move sets zero from 64 bits, sign from high bit 31
// - double move from status word writes zeros, zero set, sign clear
// - double move to program counter performs the return instead
// - after a load, stall ops using a still-pending register, and double loads until no load is pending
// - loaded bytes/halfwords right-justified, zero or sign extended
// - base naming status word in displacement/io modes selects absolute forms, content ignored
module load_store_move_unit (
   input wire logic clk,
   input wire logic reset,
   input wire logic opValid,
   output logic opReady,
   input wire lsu_pkg::op_t opKind,
   input wire lsu_pkg::mode_t addrMode,
   input wire lsu_pkg::dtype_t dataType,
   input wire logic baseIsStatus,
   input wire logic srcIsStatus,
   input wire logic dstIsPc,
   input wire logic pairIsBase,
   input wire logic [5:0] useRegA,
   input wire logic [5:0] useRegB,
   input wire logic [5:0] srcReg,
   input wire logic [5:0] pairReg,
   input wire logic [31:0] baseVal,
   input wire logic [31:0] dispVal,
   input wire logic [31:0] srcVal,
   input wire logic [31:0] pairVal,
   input wire logic [31:0] immVal,
   output logic baseWrEn,
   output logic [31:0] baseWrData,
   output logic dstWrEn,
   output logic dstDouble,
   output logic [31:0] dstHi,
   output logic [31:0] dstLo,
   output logic flagWrEn,
   output logic zeroFlag,
   output logic signFlag,
   output logic ovWrEn,
   output logic ovFlag,
   output logic returnOp,
   output logic rangeTrap,
   output logic illegalOp,
   output logic memValid,
   input wire logic memReady,
   output logic [31:0] memAddr,
   output logic memIo,
   output logic memWrite,
   input wire logic dataDemand,
   output logic storeAvail,
   output logic [31:0] storeData,
   output logic [3:0] storeByteEn,
   input wire logic loadValid,
   input wire logic [31:0] loadData,
   output logic regWrEn,
   output logic [5:0] regWrAddr,
   output logic [31:0] regWrData,
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   import lsu_pkg::*;

   typedef struct packed {
      sentry_t [1:0] sq;
      logic [1:0] sCount;
      lentry_t [1:0] lq;
      logic [1:0] lCount;
      logic memValid;
      logic [31:0] memAddr;
      logic memIo;
      logic memWrite;
      logic secValid;
      logic [31:0] secAddr;
      logic secIo;
      logic secWrite;
      logic baseWrEn;
      logic [31:0] baseWrData;
      logic dstWrEn;
      logic dstDouble;
      logic [31:0] dstHi;
      logic [31:0] dstLo;
      logic flagWrEn;
      logic zeroFlag;
      logic signFlag;
      logic ovWrEn;
      logic ovFlag;
      logic returnOp;
      logic rangeTrap;
      logic illegalOp;
      logic regWrEn;
      logic [5:0] regWrAddr;
      logic [31:0] regWrData;
      logic awHave;
      logic [31:0] awAddr;
      logic wHave;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic issueHold;
      logic [15:0] trapCount;
   } state_t;

   state_t s, next_s;
   logic isMem, isDouble, legal, hazard, addrFree, roomOk, accept;
   logic absForm, baseUpd;
   logic [31:0] accAddr, stepBase, srcData, pairData;
   logic rangeBad;

   // lane placement of a store entry
   function automatic logic [31:0] placeData(sentry_t e);
      unique case (e.kind)
         DT_BS, DT_BU: placeData = {24'h0, e.data[7:0]} << {e.lane, 3'b000};
         DT_HS, DT_HU: placeData = {16'h0, e.data[15:0]} << {e.lane[1], 4'h0};
         default: placeData = e.data;
      endcase
   endfunction : placeData

   // byte write enables of a store entry
   function automatic logic [3:0] laneEnables(sentry_t e);
      unique case (e.kind)
         DT_BS, DT_BU: laneEnables = 4'h1 << e.lane;
         DT_HS, DT_HU: laneEnables = 4'h3 << {e.lane[1], 1'b0};
         default: laneEnables = 4'hf;
      endcase
   endfunction : laneEnables

   // extraction and extension of returned load data
   function automatic logic [31:0] extendLoad(logic [31:0] d, lentry_t e);
      logic [31:0] b;
      logic [31:0] h;
      b = d >> {e.lane, 3'b000};
      h = d >> {e.lane[1], 4'h0};
      unique case (e.kind)
         DT_BS: extendLoad = {{24{b[7]}}, b[7:0]};
         DT_BU: extendLoad = {24'h0, b[7:0]};
         DT_HS: extendLoad = {{16{h[15]}}, h[15:0]};
         DT_HU: extendLoad = {16'h0, h[15:0]};
         default: extendLoad = d;
      endcase
   endfunction : extendLoad

   // issue decode: legality, hazards, room, addresses
   always_comb begin
      isMem = (opKind == OP_LOAD) || (opKind == OP_STORE);
      isDouble = dataType == DT_D;
      unique case (addrMode)
         AM_REG, AM_POSTINC, AM_IO: legal = isDouble || dataType == DT_W;
         AM_STACK: legal = dataType == DT_W;
         default: legal = 1'b1;
      endcase
      hazard = 1'b0;
      for (int i = 0; i < 2; i++) begin
         if (2'(i) < s.lCount && (s.lq[i].dest == useRegA || s.lq[i].dest == useRegB)) begin
            hazard = 1'b1;
         end
      end
      addrFree = !s.memValid || memReady;
      if (opKind == OP_STORE) begin
         roomOk = isDouble ? s.sCount == 2'd0 : s.sCount != STORE_DEPTH;
      end else begin
         roomOk = isDouble ? s.lCount == 2'd0 : s.lCount != LOAD_DEPTH;
      end
      opReady = !s.issueHold && !hazard && (!isMem || (addrFree && !s.secValid && roomOk));
      accept = opValid && opReady;
      absForm = baseIsStatus && (addrMode == AM_DISP || addrMode == AM_IO);
      if (addrMode == AM_DISP || addrMode == AM_IO) begin
         accAddr = (absForm ? 32'h0 : baseVal) + dispVal;
      end else begin
         accAddr = baseVal;
      end
      baseUpd = addrMode == AM_POSTINC || addrMode == AM_NEXT || addrMode == AM_STACK;
      stepBase = (addrMode == AM_POSTINC) ? baseVal + (isDouble ? DWORD_STEP : WORD_STEP)
         : baseVal + dispVal;
      srcData = srcIsStatus ? 32'h0 : srcVal;
      if (srcIsStatus) begin
         pairData = 32'h0;
      end else if (pairIsBase && (addrMode == AM_NEXT || addrMode == AM_POSTINC)) begin
         pairData = stepBase;
      end else begin
         pairData = pairVal;
      end
      rangeBad = (dataType == DT_BS && |srcData[31:7] && !(&srcData[31:7]))
         || (dataType == DT_HS && |srcData[31:15] && !(&srcData[31:15]));
   end

   // next state of pipelines, address channel, results and registers
   always_comb begin
      next_s = s;
      next_s.baseWrEn = 1'b0;
      next_s.dstWrEn = 1'b0;
      next_s.flagWrEn = 1'b0;
      next_s.ovWrEn = 1'b0;
      next_s.returnOp = 1'b0;
      next_s.rangeTrap = 1'b0;
      next_s.illegalOp = 1'b0;
      next_s.regWrEn = 1'b0;
      // drain store head on demand
      if (dataDemand && s.sCount != 2'd0) begin
         next_s.sq[0] = s.sq[1];
         next_s.sCount = s.sCount - 2'd1;
      end
      // retire load head into its register
      if (loadValid && s.lCount != 2'd0) begin
         next_s.lq[0] = s.lq[1];
         next_s.lCount = s.lCount - 2'd1;
         next_s.regWrEn = 1'b1;
         next_s.regWrAddr = s.lq[0].dest;
         next_s.regWrData = extendLoad(loadData, s.lq[0]);
      end
      // address channel and pending second access
      if (s.memValid && memReady) begin
         next_s.memValid = 1'b0;
      end
      if (s.secValid && addrFree) begin
         next_s.memValid = 1'b1;
         next_s.memAddr = s.secAddr;
         next_s.memIo = s.secIo;
         next_s.memWrite = s.secWrite;
         next_s.secValid = 1'b0;
      end
      if (accept) begin
         unique case (opKind)
            OP_LOAD, OP_STORE: begin
               if (!legal) begin
                  next_s.illegalOp = 1'b1;
               end else begin
                  next_s.memValid = 1'b1;
                  next_s.memAddr = accAddr;
                  next_s.memIo = addrMode == AM_IO;
                  next_s.memWrite = opKind == OP_STORE;
                  next_s.secValid = isDouble;
                  next_s.secAddr = accAddr + WORD_STEP;
                  next_s.secIo = addrMode == AM_IO;
                  next_s.secWrite = opKind == OP_STORE;
                  next_s.baseWrEn = baseUpd;
                  next_s.baseWrData = stepBase;
                  if (opKind == OP_STORE) begin
                     next_s.sq[next_s.sCount[0]] = '{srcData, accAddr[1:0], dataType};
                     next_s.sCount = next_s.sCount + 2'd1;
                     if (isDouble) begin
                        next_s.sq[next_s.sCount[0]] = '{pairData, accAddr[1:0], dataType};
                        next_s.sCount = next_s.sCount + 2'd1;
                     end
                     next_s.rangeTrap = rangeBad;
                  end else begin
                     next_s.lq[next_s.lCount[0]] = '{srcReg, accAddr[1:0], dataType};
                     next_s.lCount = next_s.lCount + 2'd1;
                     if (isDouble) begin
                        next_s.lq[next_s.lCount[0]] = '{pairReg, accAddr[1:0], dataType};
                        next_s.lCount = next_s.lCount + 2'd1;
                     end
                  end
               end
            end
            OP_MOVW, OP_IMMEDIATE_COPY_OP: begin
               next_s.dstWrEn = 1'b1;
               next_s.dstDouble = 1'b0;
               next_s.dstHi = (opKind == OP_IMMEDIATE_COPY_OP) ? immVal : srcVal;
               next_s.flagWrEn = 1'b1;
               next_s.zeroFlag = next_s.dstHi == 32'h0;
               next_s.signFlag = next_s.dstHi[31];
               next_s.ovWrEn = opKind == OP_IMMEDIATE_COPY_OP;
               next_s.ovFlag = 1'b0;
            end
            OP_DOUBLE_COPY_OP: begin
               if (dstIsPc) begin
                  next_s.returnOp = 1'b1;
               end else begin
                  next_s.dstWrEn = 1'b1;
                  next_s.dstDouble = 1'b1;
                  next_s.dstHi = srcData;
                  next_s.dstLo = srcIsStatus ? 32'h0 : pairVal;
                  next_s.flagWrEn = 1'b1;
                  next_s.zeroFlag = (next_s.dstHi | next_s.dstLo) == 32'h0;
                  next_s.signFlag = next_s.dstHi[31];
               end
            end
            default: begin
            end
         endcase
      end
      // register bus: write side
      if (awvalid && awready) begin
         next_s.awHave = 1'b1;
         next_s.awAddr = awaddr;
      end
      if (wvalid && wready) begin
         next_s.wHave = 1'b1;
         next_s.wData = wdata;
         next_s.wStrb = wstrb;
      end
      if (s.bValid && bready) begin
         next_s.bValid = 1'b0;
      end
      if (s.awHave && s.wHave && !s.bValid) begin
         next_s.awHave = 1'b0;
         next_s.wHave = 1'b0;
         next_s.bValid = 1'b1;
         next_s.bResp = RESP_OKAY;
         if (s.awAddr == REG_CTRL) begin
            if (s.wStrb[0]) begin
               next_s.issueHold = s.wData[CTRL_HOLD_BIT];
            end
         end else if (s.awAddr == REG_TRAPS) begin
            next_s.trapCount = 16'h0;
         end else if (s.awAddr != REG_STATUS) begin
            next_s.bResp = RESP_SLVERR;
         end
      end
      // a trap in the clearing cycle still counts
      if (next_s.rangeTrap) begin
         next_s.trapCount = next_s.trapCount + 16'h1;
      end
      // register bus: read side
      if (s.rValid && rready) begin
         next_s.rValid = 1'b0;
      end
      if (arvalid && arready) begin
         next_s.rValid = 1'b1;
         next_s.rResp = RESP_OKAY;
         if (araddr == REG_CTRL) begin
            next_s.rData = {31'h0, s.issueHold};
         end else if (araddr == REG_STATUS) begin
            next_s.rData = {26'h0, s.lCount, s.sCount, s.secValid, s.memValid};
         end else if (araddr == REG_TRAPS) begin
            next_s.rData = {16'h0, s.trapCount};
         end else begin
            next_s.rData = 32'h0;
            next_s.rResp = RESP_SLVERR;
         end
      end
   end

   // state register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // outputs
   assign baseWrEn = s.baseWrEn;
   assign baseWrData = s.baseWrData;
   assign dstWrEn = s.dstWrEn;
   assign dstDouble = s.dstDouble;
   assign dstHi = s.dstHi;
   assign dstLo = s.dstLo;
   assign flagWrEn = s.flagWrEn;
   assign zeroFlag = s.zeroFlag;
   assign signFlag = s.signFlag;
   assign ovWrEn = s.ovWrEn;
   assign ovFlag = s.ovFlag;
   assign returnOp = s.returnOp;
   assign rangeTrap = s.rangeTrap;
   assign illegalOp = s.illegalOp;
   assign memValid = s.memValid;
   assign memAddr = s.memAddr;
   assign memIo = s.memIo;
   assign memWrite = s.memWrite;
   assign storeAvail = s.sCount != 2'd0;
   assign storeData = placeData(s.sq[0]);
   assign storeByteEn = laneEnables(s.sq[0]);
   assign regWrEn = s.regWrEn;
   assign regWrAddr = s.regWrAddr;
   assign regWrData = s.regWrData;
   assign awready = !s.awHave && !s.bValid;
   assign wready = !s.wHave && !s.bValid;
   assign bvalid = s.bValid;
   assign bresp = s.bResp;
   assign arready = !s.rValid;
   assign rvalid = s.rValid;
   assign rdata = s.rData;
   assign rresp = s.rResp;

   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_postinc_step: assert property (accept && isMem && legal && addrMode == AM_POSTINC
      |=> baseWrEn && baseWrData == $past(baseVal) + ($past(isDouble) ? 32'h8 : 32'h4))
      else $error("postincrement step wrong");
   a_next_base: assert property (accept && isMem && legal && addrMode == AM_NEXT
      |=> baseWrEn && baseWrData == $past(baseVal) + $past(dispVal) && memAddr == $past(baseVal))
      else $error("next mode base wrong");
   a_single_access: assert property (accept && isMem && !isDouble |=> !s.secValid)
      else $error("second access on single");
   a_second_addr: assert property (accept && isMem && legal && isDouble
      |=> s.secValid && s.secAddr == memAddr + 32'h4)
      else $error("second address wrong");
   a_byte_lane: assert property (storeAvail && (s.sq[0].kind == DT_BS || s.sq[0].kind == DT_BU)
      |-> $onehot(storeByteEn))
      else $error("byte store enables wrong");
   a_range_trap: assert property (accept && opKind == OP_STORE && legal && rangeBad
      |=> rangeTrap ##1 (!rangeTrap || $past(accept)))
      else $error("range trap missing");
   a_status_zero: assert property (accept && opKind == OP_STORE && legal && srcIsStatus
      && s.sCount == 2'd0 && !dataDemand |=> s.sq[0].data == 32'h0)
      else $error("status source not zero");
   a_full_stall: assert property (opKind == OP_STORE && s.sCount == STORE_DEPTH |-> !opReady)
      else $error("issue while pipe full");
   a_double_copy_op_flags: assert property (accept && opKind == OP_DOUBLE_COPY_OP && !dstIsPc
      |=> zeroFlag == (($past(srcData) | ($past(srcIsStatus) ? 32'h0 : $past(pairVal))) == 32'h0)
      && signFlag == $past(srcData[31]))
      else $error("double move flags wrong");
   a_return_op: assert property (accept && opKind == OP_DOUBLE_COPY_OP && dstIsPc |=> returnOp && !dstWrEn)
      else $error("return not taken");
   c_double_store: cover property (accept && opKind == OP_STORE && isDouble ##[1:4] memValid);
   c_load_return: cover property (regWrEn);
   c_pipe_full: cover property (s.sCount == STORE_DEPTH);
   c_move_double: cover property (accept && opKind == OP_DOUBLE_COPY_OP);
endmodule : load_store_move_unit

/* bench/mem_ctrl_model.sv */
// memory control model taking addresses and pulling store data
module mem_ctrl_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic slow,
   input wire logic memValid,
   output logic memReady,
   input wire logic [31:0] memAddr,
   input wire logic memWrite,
   output logic dataDemand,
   input wire logic storeAvail,
   input wire logic [31:0] storeData,
   input wire logic [3:0] storeByteEn,
   output logic loadValid,
   output logic [31:0] loadData,
   output logic [31:0] lastA,
   output logic [31:0] lastD,
   output logic [3:0] lastE,
   output int nw
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] aq[$];
   // address taken at once unless told to stall
   assign memReady = memValid && !slow;
   // one store entry pulled per demand, loads answered next cycle
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         aq.delete();
         nw <= 0;
         dataDemand <= 1'b0;
         loadValid <= 1'b0;
         loadData <= 32'h0;
      end else begin
         if (memValid && memReady && memWrite) aq.push_back(memAddr);
         if (dataDemand) begin
            lastD <= storeData;
            lastE <= storeByteEn;
            lastA <= aq.pop_front();
            nw <= nw + 1;
         end
         dataDemand <= !dataDemand && storeAvail && aq.size() > 0 && !slow;
         loadValid <= memValid && memReady && !memWrite;
         // released data lines show a changing pattern
         loadData <= (memValid && memReady && !memWrite) ? 32'h85858585 : ~loadData;
      end
   end
endmodule : mem_ctrl_model

/* bench/tb_load_store_move_unit.sv */
// self-checking bench for the load/store and move unit
module tb_load_store_move_unit import lsu_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic slow = 1'b0;
   logic opValid, opReady, baseIsStatus, srcIsStatus, dstIsPc, pairIsBase;
   op_t opKind;
   mode_t addrMode;
   dtype_t dataType;
   logic [5:0] useRegA, useRegB, srcReg, pairReg, regWrAddr;
   logic [31:0] baseVal, dispVal, srcVal, pairVal, immVal, baseWrData, dstHi, dstLo;
   logic baseWrEn, dstWrEn, dstDouble, flagWrEn, zeroFlag, signFlag, ovWrEn, ovFlag;
   logic returnOp, rangeTrap, illegalOp, memValid, memReady, memIo, memWrite;
   logic dataDemand, storeAvail, loadValid, regWrEn;
   logic [31:0] memAddr, storeData, loadData, regWrData, lastA, lastD;
   logic [3:0] storeByteEn, wstrb, lastE, laneOr;
   logic [31:0] awaddr, wdata, araddr, rdata, rd;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp, rr;
   int failures, tests_run, cyc, sn, nw;
   logic [31:0] tv[4] = '{32'h80, 32'hffffff80, 32'h8000, 32'hffff8000};
   mode_t im[4] = '{AM_IO, AM_STACK, AM_REG, AM_POSTINC};
   dtype_t it[4] = '{DT_BU, DT_HS, DT_BS, DT_HU};
   logic [31:0] lx[5] = '{32'hffffff85, 32'h85, 32'hffff8585, 32'h8585, 32'h85858585};
   op_t mk[5] = '{OP_MOVW, OP_MOVW, OP_DOUBLE_COPY_OP, OP_DOUBLE_COPY_OP, OP_IMMEDIATE_COPY_OP};
   logic [3:0] mq[5] = '{4'h0, 4'h0, 4'h0, 4'h4, 4'h0};
   logic [31:0] ms[5] = '{32'h0, 32'h80000001, 32'h0, 32'h5, 32'h80000000};
   logic [31:0] mp[5] = '{32'h0, 32'h0, 32'h1, 32'h6, 32'h0};
   logic [3:0] mf[5] = '{4'hc, 4'ha, 4'h8, 4'hc, 4'hb};

   load_store_move_unit u_load_store_move_unit (.clk, .reset, .opValid, .opReady, .opKind,
      .addrMode, .dataType, .baseIsStatus, .srcIsStatus, .dstIsPc, .pairIsBase, .useRegA,
      .useRegB, .srcReg, .pairReg, .baseVal, .dispVal, .srcVal, .pairVal, .immVal, .baseWrEn,
      .baseWrData, .dstWrEn, .dstDouble, .dstHi, .dstLo, .flagWrEn, .zeroFlag, .signFlag,
      .ovWrEn, .ovFlag, .returnOp, .rangeTrap, .illegalOp, .memValid, .memReady, .memAddr,
      .memIo, .memWrite, .dataDemand, .storeAvail, .storeData, .storeByteEn, .loadValid,
      .loadData, .regWrEn, .regWrAddr, .regWrData, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready);
   mem_ctrl_model u_mem_ctrl_model (.clk, .reset, .slow, .memValid, .memReady, .memAddr,
      .memWrite, .dataDemand, .storeAvail, .storeData, .storeByteEn, .loadValid, .loadData,
      .lastA, .lastD, .lastE, .nw);

   // clock and hang guard
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         conclude();
      end
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   function automatic logic [31:0] msk(input logic [3:0] e);
      return {{8{e[3]}}, {8{e[2]}}, {8{e[1]}}, {8{e[0]}}};
   endfunction : msk

   task automatic op(input op_t k, input mode_t m, input dtype_t t, input logic [3:0] q,
         input logic [31:0] b, d, s, p);
      @(posedge clk);
      opKind <= k;
      addrMode <= m;
      dataType <= t;
      {baseIsStatus, srcIsStatus, dstIsPc, pairIsBase} <= q;
      {baseVal, dispVal, srcVal, pairVal, immVal} <= {b, d, s, p, s};
      opValid <= 1'b1;
      do @(posedge clk); while (opReady !== 1'b1);
      opValid <= 1'b0;
      #1;
   endtask : op

   // wait for the next logged store write
   task automatic ws;
      sn++;
      repeat (60) if (nw < sn) @(posedge clk);
      #1;
   endtask : ws

   task automatic wl;
      repeat (30) if (regWrEn !== 1'b1) begin
         @(posedge clk);
         #1;
      end
   endtask : wl

   task automatic axw(input logic [31:0] a, input logic [31:0] d);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge clk);
      {awaddr, wdata, wstrb} <= {a, d, 4'hf};
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(posedge clk);
         ad = ad | awready;
         wd = wd | wready;
         awvalid <= !ad;
         wvalid <= !wd;
      end while (!(ad && wd));
      do @(posedge clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", RESP_OKAY, bresp);
   endtask : axw

   task automatic axr(input logic [31:0] a);
      @(posedge clk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      rd = rdata;
      rr = rresp;
   endtask : axr

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude

   // main sequence
   initial begin
      {opValid, baseIsStatus, srcIsStatus, dstIsPc, pairIsBase} = '0;
      opKind = OP_NONE;
      addrMode = AM_REG;
      dataType = DT_W;
      {useRegA, useRegB, srcReg, pairReg} = {6'h0, 6'h0, 6'h5, 6'h6};
      {baseVal, dispVal, srcVal, pairVal, immVal, awaddr, wdata, araddr, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {failures, tests_run, cyc, sn, laneOr} = '0;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      op(OP_STORE, AM_DISP, DT_W, 4'h0, 32'h1000, 32'h10, 32'hdeadbeef, 32'h0);
      chk("addr", 32'h1010, memAddr);
      ws;
      chk("sdata", 32'hdeadbeef, lastD);
      chk("sen", 32'hf, lastE);
      op(OP_STORE, AM_DISP, DT_D, 4'h4, 32'h2000, 32'h0, 32'h1234, 32'h5678);
      ws;
      chk("sz0", 32'h0, lastD);
      ws;
      chk("sz1", 32'h0, lastD);
      chk("sa1", 32'h2004, lastA);
      // far side stalls while moves keep issuing
      slow = 1'b1;
      op(OP_STORE, AM_POSTINC, DT_D, 4'h0, 32'h100, 32'h0, 32'ha, 32'hb);
      chk("pbase", 32'h108, baseWrData);
      chk("pa0", 32'h100, memAddr);
      for (int i = 0; i < 5; i++) begin
         op(mk[i], AM_REG, DT_W, mq[i], 32'h0, 32'h0, ms[i], mp[i]);
         chk("flags", mf[i], {flagWrEn, zeroFlag, signFlag, ovWrEn});
         if (mk[i] == OP_DOUBLE_COPY_OP) chk("dlo", mp[i] & {32{!mq[i][2]}}, dstLo);
         if (mk[i] == OP_DOUBLE_COPY_OP) chk("dhi", 32'h0, dstHi);
      end
      chk("ov", 1'b0, ovFlag);
      op(OP_DOUBLE_COPY_OP, AM_REG, DT_W, 4'h2, 32'h0, 32'h0, 32'h1, 32'h2);
      chk("ret", 2'b10, {returnOp, dstWrEn});
      chk("pend", 1'b1, storeAvail);
      slow = 1'b0;
      ws;
      chk("pd0", 32'ha, lastD);
      ws;
      chk("pa1", 32'h104, lastA);
      chk("pd1", 32'hb, lastD);
      op(OP_STORE, AM_NEXT, DT_D, 4'h1, 32'h300, 32'h20, 32'ha, 32'hb);
      chk("nbase", 32'h320, baseWrData);
      ws;
      chk("na0", 32'h300, lastA);
      ws;
      chk("na1", 32'h304, lastA);
      chk("nd1", 32'h320, lastD);
      op(OP_STORE, AM_STACK, DT_W, 4'h0, 32'h400, 32'hfffffffc, 32'h7, 32'h0);
      chk("sbase", 32'h3fc, baseWrData);
      ws;
      repeat (10) @(posedge clk);
      chk("once", sn, nw);
      for (int i = 0; i < 6; i++) begin
         op(OP_STORE, AM_DISP, i < 4 ? DT_BU : DT_HU, 4'h0, 32'h40, i < 4 ? i : 2 * i - 8,
            32'h1245a5, 32'h0);
         ws;
         laneOr |= lastE;
         chk("ones", i < 4 ? 1 << i : 3 << 2 * i - 8, lastE);
         chk("lane", msk(lastE) & (i < 4 ? 32'ha5a5a5a5 : 32'h45a545a5),
            msk(lastE) & lastD);
      end
      chk("lanes", 32'hf, laneOr);
      for (int i = 0; i < 4; i++) begin
         op(OP_STORE, AM_DISP, i < 2 ? DT_BS : DT_HS, 4'h0, 32'h60, 32'h0, tv[i], 32'h0);
         chk("trap", i % 2 == 0, rangeTrap);
         ws;
         chk("trapwr", sn, nw);
      end
      axr(REG_TRAPS);
      chk("tcount", 32'h2, rd & 32'hffff);
      axw(REG_TRAPS, 32'h0);
      axr(REG_TRAPS);
      chk("tclear", 32'h0, rd & 32'hffff);
      for (int i = 0; i < 4; i++) begin
         op(OP_LOAD, im[i], it[i], 4'h0, 32'h80, 32'h0, 32'h0, 32'h0);
         chk("illegal", 1'b1, illegalOp);
         chk("noacc", 1'b0, memValid);
      end
      op(OP_LOAD, AM_IO, DT_W, 4'h8, 32'h999, 32'h40, 32'h0, 32'h0);
      chk("ioaddr", 32'h40, memAddr);
      chk("io", 1'b1, memIo);
      @(posedge clk) useRegA <= 6'h5;
      #1 chk("stall", 1'b0, opReady);
      wl;
      chk("ldreg", 6'h5, regWrAddr);
      chk("go", 1'b1, opReady);
      for (int i = 0; i < 5; i++) begin
         op(OP_LOAD, AM_NEXT, dtype_t'(i), 4'h0, 32'h500, 32'h4, 32'h0, 32'h0);
         wl;
         chk("ext", lx[i], regWrData);
      end
      axw(REG_CTRL, 32'h1);
      chk("hold", 1'b0, opReady);
      axw(REG_CTRL, 32'h0);
      chk("run", 1'b1, opReady);
      axr(32'h10);
      chk("unmap", RESP_SLVERR, rr);
      conclude();
   end
endmodule : tb_load_store_move_unit
